// ==== inc/sepc_pkg.sv ====
// shared constants and types of the serial eeprom protocol core
package sepc_pkg;

  // instruction opcodes, shifted in msb first
  localparam logic [7:0] OP_SET_LATCH = 8'h06;
  localparam logic [7:0] OP_CLR_LATCH = 8'h04;
  localparam logic [7:0] OP_STAT_RD   = 8'h05;
  localparam logic [7:0] OP_STAT_WR   = 8'h01;
  localparam logic [7:0] OP_MEM_RD    = 8'h03;
  localparam logic [7:0] OP_MEM_WR    = 8'h02;

  // status register bit positions
  localparam int ST_BUSY  = 0;
  localparam int ST_LATCH = 1;
  localparam int ST_BG_LO = 2;
  localparam int ST_BG_HI = 3;
  localparam int ST_GPE   = 7;

  // block guard encodings
  localparam logic [1:0] BG_NONE    = 2'h0;
  localparam logic [1:0] BG_QUARTER = 2'h1;
  localparam logic [1:0] BG_HALF    = 2'h2;
  localparam logic [1:0] BG_ALL     = 2'h3;
  localparam logic [1:0] TOP_QUARTER = 2'h3;

  // array geometry
  localparam int PAGE_BYTES = 32;
  localparam int PAGE_AW    = 5;
  localparam int ADDR_W_8K  = 10;
  localparam int ADDR_IN_W  = 16;
  localparam logic [2:0] LAST_BIT = 3'h7;

  // self-timed write cycle, longest time rounds down
  localparam int T_WC_NS       = 5000000;
  localparam int CLK_PERIOD_NS = 4;
  localparam int WC_CYCLES     = T_WC_NS / CLK_PERIOD_NS;

  // nonvolatile status content at power-up
  localparam logic [7:0] NV_STATUS_INIT = 8'h00;

  // synchroniser reset levels: select and guard high, serial clock low
  localparam logic [2:0] PIN_SYNC_INIT  = 3'h6;
  localparam logic [7:0] STAT_SYNC_INIT = 8'h00;

  typedef enum logic [2:0] {
    SEPC_L_OP,
    SEPC_L_ADDR_HI,
    SEPC_L_ADDR_LO,
    SEPC_L_DATA,
    SEPC_L_STAT_IN,
    SEPC_L_STAT_OUT,
    SEPC_L_READ,
    SEPC_L_IGNORE
  } sepc_link_st_t;

endpackage

// ==== design/sepc_sync.sv ====
// three-flop synchroniser with agreement filter on the last two stages
`timescale 1ns/1ps
module sepc_sync #(
  parameter int         W    = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input  wire logic         i_clk,
  input  wire logic         i_nrst,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  // s1 feeds only s2; a bit moves on once s2 and s3 agree
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      s1  <= INIT;
      s2  <= INIT;
      s3  <= INIT;
      o_q <= INIT;
    end else begin
      s1 <= i_d;
      s2 <= s1;
      s3 <= s2;
      for (int i = 0; i < W; i++) begin
        if (s2[i] == s3[i]) begin
          o_q[i] <= s3[i];
        end
      end
    end
  end
endmodule

// ==== design/sepc_wr_timer.sv ====
// self-timed programming cycle counter
`timescale 1ns/1ps
module sepc_wr_timer #(
  parameter int CYC = sepc_pkg::WC_CYCLES
) (
  input  wire logic i_clk,
  input  wire logic i_nrst,
  input  wire logic i_start,
  output logic      o_busy,
  output logic      o_done
);
  localparam int CW = $clog2(CYC + 1);
  localparam logic [CW-1:0] LOAD = CW'(CYC);
  localparam logic [CW-1:0] ONE  = CW'(1);

  logic [CW-1:0] cnt;

  assign o_busy = (cnt != '0);
  assign o_done = (cnt == ONE);

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      cnt <= '0;
    end else if (i_start && !o_busy) begin
      cnt <= LOAD;
    end else if (o_busy) begin
      cnt <= cnt - ONE;
    end
  end
endmodule

// ==== design/sepc_core.sv ====
// serial eeprom spi front end, command logic, status and array
//
// Behaviour
// RULE_01: serial input bits are sampled on rising serial clock edges.
// RULE_02: serial output bits change on falling serial clock edges.
// RULE_03: deselected means output released, standby; running program cycle continues.
// RULE_04: host frames each session with select_n; parsing restarts every session.
// RULE_05: pause_input low freezes all transfer state until it returns high.
// RULE_06: first eight bits form the opcode; only six opcodes act.
// RULE_07: set latch 06h, clear latch 04h, status read 05h, msb first.
// RULE_08: status write 01h, memory read 03h, memory write 02h.
// RULE_09: status holds guard enable, zeros, two block guards, latch, busy.
// RULE_10: busy reads one during programming, zero otherwise; host cannot write it.
// RULE_11: set latch command sets the latch; clear latch command clears it.
// RULE_12: block guards change only by status write and are nonvolatile.
// RULE_13: guard codes protect nothing, top quarter, top half, or everything.
// RULE_14: status writes need latch and no active guard pin; protected never writes.
// RULE_15: guard pin falling during a status write session aborts that write.
// RULE_16: with guard enable clear the guard pin is ignored.
// RULE_17: latch clear at power-up; writes need latch and unprotected address.
// RULE_18: latch sets only when select_n rises right after the opcode.
// RULE_19: sixteen address bits received; only the low array bits are used.
// RULE_20: programming starts at select_n rise; meanwhile only status read works.
// RULE_21: up to 32 bytes per page; in-page address wraps, overwriting.
// RULE_22: finished program cycle clears the write latch.
// RULE_23: status write changes only bits 2, 3 and 7.
// RULE_24: memory read streams bytes, incrementing and wrapping, until deselect.
// RULE_25: status read works any time and shifts out the whole status.
// RULE_26: while paused the output is released and serial input ignored.
// RULE_27: undefined opcode does nothing and keeps the output released.
// RULE_28: programming time is a counter of configurable length.
// RULE_29: partial byte or no data byte starts no programming.
`timescale 1ns/1ps
module sepc_core #(
  parameter int         ADDR_W    = sepc_pkg::ADDR_W_8K,
  parameter int         WC_CYCLES = sepc_pkg::WC_CYCLES,
  parameter logic [7:0] NV_INIT   = sepc_pkg::NV_STATUS_INIT
) (
  input  wire logic i_sys_clk,
  input  wire logic i_nrst,
  input  wire logic i_sck,
  input  wire logic i_select_n,
  input  wire logic i_si,
  input  wire logic i_pause_n,
  input  wire logic i_write_guard_n,
  output logic      o_so,
  output logic      o_so_oe
);
  localparam int PB = sepc_pkg::PAGE_BYTES;
  localparam int PW = sepc_pkg::PAGE_AW;
  localparam int AI = sepc_pkg::ADDR_IN_W;

  // storage: array written on the system clock only
  logic [7:0]    mem      [0:(1<<ADDR_W)-1];
  logic [7:0]    page_buf [0:PB-1];
  logic [PB-1:0] page_mask;

  // link-side captures, static once select_n has risen
  logic [7:0]        lk_op;
  logic [7:0]        lk_addr_hi;
  logic [ADDR_W-1:0] lk_addr;
  logic [7:0]        lk_stat_byte;
  logic              lk_aligned;
  logic              lk_op_only;
  logic              lk_got_data;

  // system-side state
  logic       write_latch_flag;
  logic [1:0] bg;
  logic       gpe;
  logic       pend_stat;
  logic [7:0] pend_byte;
  logic       guard_seen;
  logic       sel_n_q;
  logic       sck_q;
  logic       sess_clk;
  logic       start_any;
  logic       busy;
  logic       prog_done;
  logic       sel_n_s;
  logic       guard_n_s;
  logic       sck_s;
  logic [7:0] status;

  // block guard decode on the page start address
  function automatic logic is_guarded(input logic [1:0] code,
                                      input logic [ADDR_W-1:0] a);
    logic r;
    r = 1'b0;
    case (code)
      sepc_pkg::BG_NONE:    r = 1'b0;
      sepc_pkg::BG_QUARTER:
        r = (a[ADDR_W-1:ADDR_W-2] == sepc_pkg::TOP_QUARTER);
      sepc_pkg::BG_HALF:    r = a[ADDR_W-1];
      default:              r = 1'b1;
    endcase
    return r; // RULE_13
  endfunction

  sepc_sync #(
    .W    (3),
    .INIT (sepc_pkg::PIN_SYNC_INIT)
  ) u_pin_sync (
    .i_clk  (i_sys_clk),
    .i_nrst (i_nrst),
    .i_d    ({i_select_n, i_write_guard_n, i_sck}),
    .o_q    ({sel_n_s, guard_n_s, sck_s})
  );

  sepc_wr_timer #(
    .CYC (WC_CYCLES) // RULE_28
  ) u_timer (
    .i_clk   (i_sys_clk),
    .i_nrst  (i_nrst),
    .i_start (start_any),
    .o_busy  (busy),
    .o_done  (prog_done)
  );

  always_comb begin
    status                      = '0;
    status[sepc_pkg::ST_BUSY]   = busy; // RULE_10
    status[sepc_pkg::ST_LATCH]  = write_latch_flag;
    status[sepc_pkg::ST_BG_LO]  = bg[0];
    status[sepc_pkg::ST_BG_HI]  = bg[1];
    status[sepc_pkg::ST_GPE]    = gpe; // RULE_09
  end

  // session end decode on the system clock
  wire sess_end   = sel_n_s & ~sel_n_q;
  wire sess_start = ~sel_n_s & sel_n_q;
  // serial clock oversampled here, so it must stay well below i_sys_clk
  wire sck_rise   = sck_s & ~sck_q;
  // a session with no rising serial clock edge does nothing
  wire cmd_ok     = sess_end & sess_clk & ~busy & lk_aligned; // RULE_20
  wire guard_low  = gpe & ~guard_n_s; // RULE_16
  wire guard_set  = guard_low & ~sel_n_s;
  wire do_set     = cmd_ok & (lk_op == sepc_pkg::OP_SET_LATCH)
                    & lk_op_only; // RULE_18
  wire do_clr     = cmd_ok & (lk_op == sepc_pkg::OP_CLR_LATCH);
  wire start_stat = cmd_ok & (lk_op == sepc_pkg::OP_STAT_WR) & write_latch_flag
                    & lk_got_data & ~guard_seen & ~guard_low; // RULE_14
  wire start_mem  = cmd_ok & (lk_op == sepc_pkg::OP_MEM_WR) & write_latch_flag
                    & lk_got_data & ~is_guarded(bg, lk_addr); // RULE_17
  assign start_any = start_stat | start_mem; // RULE_29

  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      write_latch_flag        <= 1'b0; // RULE_17
      bg         <= {NV_INIT[sepc_pkg::ST_BG_HI], NV_INIT[sepc_pkg::ST_BG_LO]};
      gpe        <= NV_INIT[sepc_pkg::ST_GPE];
      pend_stat  <= 1'b0;
      pend_byte  <= '0;
      guard_seen <= 1'b0;
      sel_n_q    <= 1'b1;
      sck_q      <= 1'b0;
      sess_clk   <= 1'b0;
    end else begin
      sel_n_q <= sel_n_s;
      sck_q   <= sck_s;
      // a clock edge wins over the clear at a new session
      if (sck_rise && !sel_n_s) begin
        sess_clk <= 1'b1;
      end else if (sess_start) begin
        sess_clk <= 1'b0;
      end
      // the pin event wins over the clear at a new session
      if (guard_set) begin
        guard_seen <= 1'b1; // RULE_15
      end else if (sess_start) begin
        guard_seen <= 1'b0;
      end
      if (do_set) begin
        write_latch_flag <= 1'b1; // RULE_11
      end else if (do_clr || prog_done) begin
        write_latch_flag <= 1'b0; // RULE_22
      end
      if (start_any) begin
        pend_stat <= start_stat;
        pend_byte <= lk_stat_byte;
      end
      // only guard enable and block guards take the written value
      if (prog_done && pend_stat) begin
        gpe <= pend_byte[sepc_pkg::ST_GPE]; // RULE_23
        bg  <= {pend_byte[sepc_pkg::ST_BG_HI],
                pend_byte[sepc_pkg::ST_BG_LO]}; // RULE_12
      end
    end
  end

  // array commit at cycle start; reads are refused while busy anyway
  always_ff @(posedge i_sys_clk) begin
    if (start_mem) begin
      for (int i = 0; i < PB; i++) begin
        if (page_mask[i]) begin
          mem[{lk_addr[ADDR_W-1:PW], PW'(i)}] <= page_buf[i]; // RULE_21
        end
      end
    end
  end

  // link domain: status arrives through a synchroniser on the serial clock
  logic [7:0] stat_lk;

  sepc_sync #(
    .W    (8),
    .INIT (sepc_pkg::STAT_SYNC_INIT)
  ) u_stat_sync (
    .i_clk  (i_sck),
    .i_nrst (i_nrst),
    .i_d    (status),
    .o_q    (stat_lk)
  );

  sepc_pkg::sepc_link_st_t st;
  sepc_pkg::sepc_link_st_t next_st;
  logic [2:0]        bitc;
  logic [6:0]        sr;
  logic              tx_load;
  logic              next_tx_load;
  logic [7:0]        tx_byte;
  logic [6:0]        so_sr;
  logic              tx_en;
  logic [ADDR_W-1:0] rd_addr;
  logic [PW-1:0]     wr_ptr;

  wire busy_lk   = stat_lk[sepc_pkg::ST_BUSY];
  wire byte_done = (bitc == sepc_pkg::LAST_BIT);
  wire [7:0] byte_in = {sr, i_si};
  wire first     = (st == sepc_pkg::SEPC_L_OP) && (bitc == '0);
  wire [AI-1:0] addr_in = {lk_addr_hi, byte_in};
  wire [ADDR_W-1:0] addr_full = addr_in[ADDR_W-1:0]; // RULE_19
  wire [ADDR_W-1:0] rd_ptr =
    (st == sepc_pkg::SEPC_L_ADDR_LO) ? addr_full : rd_addr;
  wire send_stat = (st == sepc_pkg::SEPC_L_OP) ||
                   (st == sepc_pkg::SEPC_L_STAT_OUT);

  always_comb begin
    next_st      = st;
    next_tx_load = 1'b0;
    case (st)
      sepc_pkg::SEPC_L_OP: begin
        if (byte_done) begin
          next_st = sepc_pkg::SEPC_L_IGNORE; // RULE_27
          if (byte_in == sepc_pkg::OP_STAT_RD) begin
            next_st      = sepc_pkg::SEPC_L_STAT_OUT; // RULE_25
            next_tx_load = 1'b1;
          end else if (busy_lk) begin
            next_st = sepc_pkg::SEPC_L_IGNORE; // RULE_20
          end else if (byte_in == sepc_pkg::OP_MEM_RD ||
                       byte_in == sepc_pkg::OP_MEM_WR) begin
            next_st = sepc_pkg::SEPC_L_ADDR_HI;
          end else if (byte_in == sepc_pkg::OP_STAT_WR) begin
            next_st = sepc_pkg::SEPC_L_STAT_IN; // RULE_08
          end
        end
      end
      sepc_pkg::SEPC_L_ADDR_HI: begin
        if (byte_done) begin
          next_st = sepc_pkg::SEPC_L_ADDR_LO;
        end
      end
      sepc_pkg::SEPC_L_ADDR_LO: begin
        if (byte_done && lk_op == sepc_pkg::OP_MEM_RD) begin
          next_st      = sepc_pkg::SEPC_L_READ;
          next_tx_load = 1'b1;
        end else if (byte_done) begin
          next_st = sepc_pkg::SEPC_L_DATA;
        end
      end
      sepc_pkg::SEPC_L_READ: begin
        next_tx_load = byte_done; // RULE_24
      end
      sepc_pkg::SEPC_L_STAT_OUT: begin
        next_tx_load = byte_done;
      end
      sepc_pkg::SEPC_L_STAT_IN: begin
        if (byte_done) begin
          next_st = sepc_pkg::SEPC_L_IGNORE;
        end
      end
      default: begin
        next_st = st;
      end
    endcase
  end

  // select_n high clears the parser asynchronously: the clock may be stopped
  always_ff @(posedge i_sck or posedge i_select_n) begin
    if (i_select_n) begin
      st      <= sepc_pkg::SEPC_L_OP; // RULE_04
      bitc    <= '0;
      sr      <= '0;
      tx_load <= 1'b0;
    end else if (i_pause_n) begin // RULE_05
      bitc    <= bitc + 3'h1;
      sr      <= byte_in[6:0]; // RULE_01
      tx_load <= next_tx_load;
      st      <= next_st; // RULE_06
    end
  end

  // captures survive deselect so the system clock can act on them
  always_ff @(posedge i_sck) begin
    if (!i_select_n && i_pause_n) begin // RULE_26
      lk_aligned <= byte_done;
      lk_op_only <= (st == sepc_pkg::SEPC_L_OP) && byte_done;
      if (first) begin
        lk_got_data <= 1'b0;
        page_mask   <= '0;
      end
      if (next_tx_load) begin
        tx_byte <= send_stat ? stat_lk : mem[rd_ptr];
        rd_addr <= rd_ptr + ADDR_W'(1);
      end
      if (byte_done) begin
        case (st)
          sepc_pkg::SEPC_L_OP:      lk_op      <= byte_in; // RULE_07
          sepc_pkg::SEPC_L_ADDR_HI: lk_addr_hi <= byte_in;
          sepc_pkg::SEPC_L_ADDR_LO: begin
            lk_addr <= addr_full;
            wr_ptr  <= addr_full[PW-1:0];
          end
          sepc_pkg::SEPC_L_DATA: begin
            page_buf[wr_ptr]  <= byte_in;
            page_mask[wr_ptr] <= 1'b1;
            wr_ptr            <= wr_ptr + PW'(1); // RULE_21
            lk_got_data       <= 1'b1;
          end
          sepc_pkg::SEPC_L_STAT_IN: begin
            lk_stat_byte <= byte_in;
            lk_got_data  <= 1'b1;
          end
          default: begin
            lk_got_data <= lk_got_data;
          end
        endcase
      end
    end
  end

  always_ff @(negedge i_sck or posedge i_select_n) begin
    if (i_select_n) begin
      o_so  <= 1'b0;
      so_sr <= '0;
      tx_en <= 1'b0;
    end else if (i_pause_n) begin
      if (tx_load) begin
        o_so  <= tx_byte[7]; // RULE_02
        so_sr <= tx_byte[6:0];
        tx_en <= 1'b1;
      end else begin
        o_so  <= so_sr[6];
        so_sr <= {so_sr[5:0], 1'b0};
      end
    end
  end

  // released when deselected, paused, or nothing to send
  assign o_so_oe = ~i_select_n & i_pause_n & tx_en; // RULE_03
endmodule

// ==== tb/sepc_core_monitor.sv ====
// port assertions of the serial eeprom core
`timescale 1ns/1ps
module sepc_core_monitor (
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic i_sck,
  input wire logic i_select_n,
  input wire logic i_si,
  input wire logic i_pause_n,
  input wire logic i_write_guard_n,
  input wire logic o_so,
  input wire logic o_so_oe
);
  logic [7:0] n_rise;

  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_nrst);

  // serial rises of this session, oversampled: sck is 16x slower
  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst || i_select_n)
      n_rise <= 8'h00;
    else if ($rose(i_sck) && i_pause_n && n_rise != 8'hff)
      n_rise <= n_rise + 8'h01;
  end

  sequence s_drive_start;
    $rose(o_so_oe) && $stable(i_pause_n);
  endsequence
  sequence s_bit_hold;
    ($stable(o_so) || i_select_n) [*8];
  endsequence

  a_desel_quiet: assert property (i_select_n |-> !o_so_oe && !o_so)
    else $error("output active while deselected");
  a_pause_quiet: assert property (!i_pause_n |-> !o_so_oe)
    else $error("output driven while paused");
  a_so_fall_edge: assert property (!i_select_n &&
    $past(!i_select_n) && $changed(o_so) |-> !i_sck)
    else $error("serial out changed with clock high");
  a_oe_from_fall: assert property (s_drive_start |-> !i_sck)
    else $error("drive began outside a falling edge");
  a_oe_on_byte: assert property (s_drive_start |->
    n_rise >= 8'h08 && n_rise[2:0] == 3'h0)
    else $error("drive began off a byte boundary");
  a_no_early_out: assert property (n_rise < 8'h08 |-> !o_so_oe)
    else $error("drive before the opcode completed");
  a_stream_held: assert property (o_so_oe |=>
    o_so_oe || i_select_n || !i_pause_n)
    else $error("output dropped in mid stream");
  a_bit_stands: assert property (!i_select_n &&
    $changed(o_so) |=> s_bit_hold)
    else $error("serial out bit too short");
endmodule

// ==== tb/sepc_host.sv ====
// spi host model, mode (0,0), clock still between frames
`timescale 1ns/1ps
module sepc_host (
  output logic      o_sck,
  output logic      o_select_n,
  output logic      o_si,
  output logic      o_pause_n,
  input  wire logic i_so,
  input  wire logic i_so_oe
);
  logic [7:0] txb [0:7];
  logic [7:0] rxb [0:7];
  logic       oe_seen;
  logic       pause_oe;

  initial begin
    o_sck = 1'b0;
    o_select_n = 1'b0;
    o_si = 1'b0;
    o_pause_n = 1'b1;
    // a true rising select edge clears the parser before any session
    #1 o_select_n = 1'b1;
  end

  // nb whole bytes, xb trailing bits, pause after byte pb
  task automatic run(input int nb, input int xb, input int pb);
    int i;
    int b;
    oe_seen = 1'b0;
    pause_oe = 1'b0;
    #5.3 o_select_n = 1'b0;
    #30;
    for (i = 0; i <= nb; i++) begin
      for (b = 7; b >= 0; b--) begin
        if (i == nb && 7 - b >= xb)
          break;
        o_si = txb[i][b];
        #32 o_sck = 1'b1;
        rxb[i][b] = i_so;
        oe_seen |= i_so_oe;
        #32 o_sck = 1'b0;
      end
      if (i == pb) begin
        #10 o_pause_n = 1'b0;
        #100 o_si = ~o_si;
        pause_oe = i_so_oe;
        #100 o_pause_n = 1'b1;
      end
    end
    #30 o_select_n = 1'b1;
    o_si = ~o_si;
    #250;
  endtask
endmodule

// ==== tb/tb_spi_eeprom_protocol_core.sv ====
// self-checking bench of the serial eeprom core
`timescale 1ns/1ps
module tb_spi_eeprom_protocol_core;
  logic      i_sys_clk;
  logic      i_nrst;
  logic      i_write_guard_n;
  wire logic sck, sel_n, si, pause_n, so, so_oe;
  int        n_errors = 0;
  int        num_checks = 0;

  initial begin
    i_sys_clk = 1'b0;
    forever #2 i_sys_clk = ~i_sys_clk;
  end

  sepc_host H (.o_sck(sck), .o_select_n(sel_n), .o_si(si),
    .o_pause_n(pause_n), .i_so(so), .i_so_oe(so_oe));
  // short program cycle keeps the run brief
  sepc_core #(.WC_CYCLES(2000)) DUT (.i_sys_clk(i_sys_clk),
    .i_nrst(i_nrst), .i_sck(sck), .i_select_n(sel_n), .i_si(si),
    .i_pause_n(pause_n), .i_write_guard_n(i_write_guard_n),
    .o_so(so), .o_so_oe(so_oe));

  task automatic check(input string w, input logic [7:0] s,
                       input logic [7:0] e);
    num_checks++;
    if (s !== e) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", w, e, s);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // bytes right aligned in v, trailing partial byte included
  task automatic tx(input int nb, input int xb, input logic [47:0] v);
    int i;
    int nt;
    nt = nb + (xb > 0);
    for (i = 0; i < nt; i++)
      H.txb[i] = v[8*(nt-1-i) +: 8];
    H.run(nb, xb, 99);
  endtask

  task automatic rdst(input string w, input logic [7:0] e);
    tx(2, 0, 48'h0500);
    check(w, H.rxb[1], e);
  endtask

  task automatic wait_ready();
    int k;
    for (k = 0; k < 20; k++) begin
      tx(2, 0, 48'h0500);
      if (H.rxb[1][0] === 1'b0)
        return;
    end
    n_errors++;
    conclude();
  endtask

  task automatic guard(input logic v);
    @(posedge i_sys_clk) i_write_guard_n <= v;
  endtask

  task automatic t_latch();
    rdst("power-up status", 8'h00);
    tx(1, 0, 48'h06);
    rdst("latch set", 8'h02);
    tx(1, 0, 48'h04);
    rdst("latch cleared", 8'h00);
    tx(1, 1, 48'h0600);
    rdst("latch with extra bit", 8'h00);
    tx(3, 0, 48'hff0000);
    check("undefined op drive", H.oe_seen, 8'h00);
    $display("latch test done");
  endtask

  task automatic t_write();
    tx(1, 0, 48'h06);
    tx(6, 0, 48'h02fc1ea1b2c3);
    rdst("busy status", 8'h03);
    tx(4, 0, 48'h03000000);
    check("read while busy", H.oe_seen, 8'h00);
    wait_ready();
    rdst("after cycle", 8'h00);
    tx(5, 0, 48'h03001e0000);
    check("byte 1e", H.rxb[3], 8'ha1);
    check("byte 1f", H.rxb[4], 8'hb2);
    tx(1, 0, 48'h06);
    tx(5, 0, 48'h0203ffd4e5);
    wait_ready();
    tx(5, 0, 48'h0303ff0000);
    check("top byte", H.rxb[3], 8'hd4);
    check("wrapped byte", H.rxb[4], 8'hc3);
    tx(1, 0, 48'h06);
    tx(3, 4, 48'h020000f0);
    rdst("partial write", 8'h02);
    $display("write test done");
  endtask

  task automatic t_protect();
    tx(2, 0, 48'h01ff);
    wait_ready();
    rdst("status write", 8'h8c);
    tx(1, 0, 48'h06);
    tx(4, 0, 48'h02000077);
    rdst("protected write", 8'h8e);
    guard(1'b0);
    tx(2, 0, 48'h0100);
    rdst("guarded status", 8'h8e);
    guard(1'b1);
    fork
      tx(2, 0, 48'h0100);
      begin
        #200;
        guard(1'b0);
      end
    join
    rdst("guard abort", 8'h8e);
    guard(1'b1);
    tx(2, 0, 48'h0104);
    wait_ready();
    rdst("quarter guard", 8'h04);
    tx(1, 0, 48'h06);
    tx(4, 0, 48'h02030011);
    rdst("quarter refused", 8'h06);
    H.txb[0] = 8'h05;
    H.run(3, 0, 1);
    check("paused stat", H.rxb[2], 8'h06);
    check("pause drive", H.pause_oe, 8'h00);
    guard(1'b0);
    tx(2, 0, 48'h0100);
    wait_ready();
    rdst("guard ignored", 8'h00);
    tx(4, 0, 48'h03000000);
    check("kept byte", H.rxb[3], 8'hc3);
    $display("protect test done");
  endtask

  initial begin
    i_nrst = 1'b0;
    i_write_guard_n = 1'b1;
    repeat (8) @(posedge i_sys_clk);
    i_nrst <= 1'b1;
    repeat (10) @(posedge i_sys_clk);
    t_latch();
    t_write();
    t_protect();
    conclude();
  end

  // hang guard well beyond the length of a passing run
  initial begin
    #390000;
    n_errors++;
    conclude();
  end
endmodule

bind sepc_core sepc_core_monitor u_mon (.i_sys_clk(i_sys_clk),
  .i_nrst(i_nrst), .i_sck(i_sck), .i_select_n(i_select_n),
  .i_si(i_si), .i_pause_n(i_pause_n),
  .i_write_guard_n(i_write_guard_n), .o_so(o_so), .o_so_oe(o_so_oe));
